// file: logic/dsc_pkg.sv
// Purpose: constants for the double speed clock generator
// Assumes: hclk is the crystal clock, AHB-Lite register access
// Notes: Notes on behaviour follow
// Notes on behaviour
// - in standard mode core and peripherals run from the crystal clock halved.
// - in double speed mode the halving stage is bypassed for the core.
// - a new speed mode bit takes effect only on a rising edge of the half rate clock.
// - mode bit clear gives 12 crystal periods per machine cycle, set gives 6.
// - after reset the mode bit is loaded from the hardware config byte.
// - all peripheral fast select bits are ignored while the mode bit is low.
// - counter array cycle is 6 periods with its bit clear, 12 with it set.
// - serial port modes 0 and 2 cycle is 6 periods with its bit clear, 12 set.
// - timer 2 cycle is 6 periods with its bit clear, 12 with it set.
// - timer 1 cycle is 6 periods with its bit clear, 12 with it set.
// - timer 0 cycle is 6 periods with its bit clear, 12 with it set.
// - watchdog cycle is 6 periods with its bit clear, 12 with it set.
package dsc_pkg;
  localparam logic [11:0] CTL_INDEX = 12'h08f;
  localparam logic [11:0] CTL_ADDR = 12'(CTL_INDEX * 4);
  localparam logic [11:0] STAT_INDEX = 12'h090;
  localparam logic [11:0] STAT_ADDR = 12'(STAT_INDEX * 4);
  localparam logic [6:0] CTL_RESET = 7'h00;
  localparam logic [6:0] CTL_WMASK = 7'h7f;
  localparam int CFG_MODE_BIT = 0;
  localparam int MODE_BIT = 0;
  localparam int T0_BIT = 1;
  localparam int T1_BIT = 2;
  localparam int T2_BIT = 3;
  localparam int SER_BIT = 4;
  localparam int PCA_BIT = 5;
  localparam int WD_BIT = 6;
  localparam int NCH = 7;
  localparam logic [3:0] SLOW_PERIOD = 4'hc;
  localparam logic [3:0] FAST_PERIOD = 4'h6;
endpackage : dsc_pkg

// file: logic/dsc_cycle_timer.sv
// Purpose: one strobe every 6 or 12 crystal periods
// Assumes: fast may change at any cycle
// Notes: strobe is registered, high one cycle
module dsc_cycle_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fast,
  output logic stb
);
  typedef struct packed {
    logic [3:0] cnt;
    logic stb;
  } dsc_tmr_t;

  dsc_tmr_t s_reg;
  dsc_tmr_t s_next;
  logic [3:0] per;
  logic last;

  always_comb begin
    s_next = s_reg;
    per = fast ? dsc_pkg::FAST_PERIOD : dsc_pkg::SLOW_PERIOD;
    // shorter period may leave cnt above the new end
    last = s_reg.cnt >= (per - 4'h1);
    s_next.cnt = last ? 4'h0 : s_reg.cnt + 4'h1;
    s_next.stb = last;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign stb = s_reg.stb;
endmodule : dsc_cycle_timer

// file: logic/dsc_clock_gen.sv
// Purpose: core and peripheral clock enables, standard or double speed
// Assumes: hclk is the crystal input, one AHB-Lite slave, zero wait
// Notes: gated clocks are given as one cycle enables on hclk
module dsc_clock_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] hardware_config_byte,
  output logic half_clk,
  output logic core_clk_en,
  output logic double_speed_active,
  output logic machine_cycle_stb,
  output logic [5:0] periph_cycle_stb
);
  typedef struct packed {
    logic [6:0] ctl;
    logic mode;
    logic half;
    logic loaded;
    logic core_en;
    logic wr_pend;
    logic [7:0] rdata;
  } dsc_state_t;

  dsc_state_t s_reg;
  dsc_state_t s_next;
  logic aphase;
  logic sel_ctl;
  logic sel_stat;
  logic [6:0] wval;
  logic [6:0] fast_vec;
  logic [6:0] stb_vec;

  assign aphase = hsel && hready && htrans[1];
  assign sel_ctl = haddr[11:0] == dsc_pkg::CTL_ADDR;
  assign sel_stat = haddr[11:0] == dsc_pkg::STAT_ADDR;
  assign wval = hwdata[6:0] & dsc_pkg::CTL_WMASK;

  always_comb begin
    s_next = s_reg;
    // hardware config byte caught once, first edge after release
    if (!s_reg.loaded) begin
      s_next.loaded = 1'b1;
      s_next.ctl[dsc_pkg::MODE_BIT] =
        hardware_config_byte[dsc_pkg::CFG_MODE_BIT];
    end
    // write data phase; bit 7 is reserved and never stored
    if (s_reg.wr_pend) begin
      s_next.ctl = wval;
    end
    s_next.wr_pend = aphase && hwrite && sel_ctl;
    // read data latched in address phase, forwarding a pending write
    if (aphase && !hwrite) begin
      if (sel_ctl) begin
        s_next.rdata = {1'b0, s_reg.wr_pend ? wval : s_reg.ctl};
      end else if (sel_stat) begin
        s_next.rdata = {6'h00, s_reg.half, s_reg.mode};
      end else begin
        s_next.rdata = 8'h00;
      end
    end
    // half rate clock: plain toggle of the crystal clock
    s_next.half = ~s_reg.half;
    // mode bit taken only as half rises
    if (!s_reg.half) begin
      s_next.mode = s_reg.ctl[dsc_pkg::MODE_BIT];
    end
    // standard: core on half rising; double speed: every period
    s_next.core_en = s_next.mode | ~s_reg.half;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // channel 0 is the core, channels 1..6 the peripherals by bit
  genvar k;
  generate
    for (k = 0; k < dsc_pkg::NCH; k++) begin : g_ch
      // peripheral bits count only in double speed mode
      if (k == 0) begin : g_core
        assign fast_vec[k] = s_reg.mode;
      end else begin : g_periph
        assign fast_vec[k] = s_reg.mode & ~s_reg.ctl[k];
      end
      dsc_cycle_timer i_dsc_cycle_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .fast(fast_vec[k]),
        .stb(stb_vec[k])
      );
    end
  endgenerate

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, s_reg.rdata};
  assign half_clk = s_reg.half;
  assign core_clk_en = s_reg.core_en;
  assign double_speed_active = s_reg.mode;
  assign machine_cycle_stb = stb_vec[0];
  assign periph_cycle_stb = stb_vec[6:1];

  // checks

  property p_norm_half;
    @(posedge hclk) disable iff (!hresetn)
      (!s_reg.mode && $past(!s_reg.mode) && core_clk_en) |=> !core_clk_en;
  endproperty
  a_norm_half: assert property (p_norm_half)
    else $error("core enable not halved in standard mode");

  property p_norm_every2;
    @(posedge hclk) disable iff (!hresetn)
      (!s_reg.mode && !core_clk_en) ##1 !s_reg.mode |-> core_clk_en;
  endproperty
  a_norm_every2: assert property (p_norm_every2)
    else $error("core enable missing in standard mode");

  property p_fast_bypass;
    @(posedge hclk) disable iff (!hresetn)
      s_reg.mode |-> core_clk_en;
  endproperty
  a_fast_bypass: assert property (p_fast_bypass)
    else $error("core enable not every period in double speed");

  property p_mode_on_half;
    @(posedge hclk) disable iff (!hresetn)
      $changed(s_reg.mode) |-> (s_reg.half && !$past(s_reg.half));
  endproperty
  a_mode_on_half: assert property (p_mode_on_half)
    else $error("mode changed off a half rate rising edge");

  property p_mode_follows;
    @(posedge hclk) disable iff (!hresetn)
      (s_reg.loaded && s_reg.ctl[0] != s_reg.mode) ##1 $stable(s_reg.ctl[0])
        |=> (s_reg.mode == $past(s_reg.ctl[0]))
          || (s_reg.ctl[0] != $past(s_reg.ctl[0]));
  endproperty
  a_mode_follows: assert property (p_mode_follows)
    else $error("mode bit not taken within two periods");

  property p_mc12;
    @(posedge hclk) disable iff (!hresetn)
      (machine_cycle_stb && !s_reg.mode) ##1 (!s_reg.mode)[*8]
        ##1 (!s_reg.mode)[*3] |=> machine_cycle_stb;
  endproperty
  a_mc12: assert property (p_mc12)
    else $error("machine cycle not 12 periods in standard mode");

  property p_mc6;
    @(posedge hclk) disable iff (!hresetn)
      (machine_cycle_stb && s_reg.mode) ##1 s_reg.mode[*5]
        |-> !machine_cycle_stb ##1 machine_cycle_stb;
  endproperty
  a_mc6: assert property (p_mc6)
    else $error("machine cycle not 6 periods in double speed");

  property p_load_hcb;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s_reg.loaded) && !$past(s_reg.wr_pend)
        |-> s_reg.ctl[0] == $past(hardware_config_byte[0]);
  endproperty
  a_load_hcb: assert property (p_load_hcb)
    else $error("mode bit not loaded from config byte");

  property p_ignore_norm;
    @(posedge hclk) disable iff (!hresetn)
      !s_reg.mode |-> fast_vec == 7'h00;
  endproperty
  a_ignore_norm: assert property (p_ignore_norm)
    else $error("peripheral fast select active in standard mode");

  property p_pca6;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[5] && fast_vec[5]) ##1 fast_vec[5][*5] |=> stb_vec[5];
  endproperty
  a_pca6: assert property (p_pca6)
    else $error("counter array cycle not 6 periods");

  property p_ser6;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[4] && fast_vec[4]) ##1 fast_vec[4][*5] |=> stb_vec[4];
  endproperty
  a_ser6: assert property (p_ser6)
    else $error("serial port cycle not 6 periods");

  property p_t2_6;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[3] && fast_vec[3]) ##1 fast_vec[3][*5] |=> stb_vec[3];
  endproperty
  a_t2_6: assert property (p_t2_6)
    else $error("timer 2 cycle not 6 periods");

  property p_t1_6;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[2] && fast_vec[2]) ##1 fast_vec[2][*5] |=> stb_vec[2];
  endproperty
  a_t1_6: assert property (p_t1_6)
    else $error("timer 1 cycle not 6 periods");

  property p_t0_12;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[1] && !fast_vec[1]) ##1 (!fast_vec[1])[*8]
        ##1 (!fast_vec[1])[*3] |=> stb_vec[1];
  endproperty
  a_t0_12: assert property (p_t0_12)
    else $error("timer 0 slow cycle not 12 periods");

  property p_t0_gap;
    @(posedge hclk) disable iff (!hresetn)
      stb_vec[1] |=> (!stb_vec[1])[*5];
  endproperty
  a_t0_gap: assert property (p_t0_gap)
    else $error("timer 0 strobes closer than 6 periods");

  property p_wd_sel;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[6] && s_reg.mode && s_reg.ctl[6]) ##1
        (s_reg.mode && s_reg.ctl[6])[*6] |-> !stb_vec[6];
  endproperty
  a_wd_sel: assert property (p_wd_sel)
    else $error("watchdog select set yet cycle is 6 periods");

  property p_wd6;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[6] && fast_vec[6]) ##1 fast_vec[6][*5] |=> stb_vec[6];
  endproperty
  a_wd6: assert property (p_wd6)
    else $error("watchdog cycle not 6 periods");

  property p_ctl_write;
    @(posedge hclk) disable iff (!hresetn)
      (aphase && hwrite && sel_ctl) ##1 1'b1 |=> s_reg.ctl == $past(wval);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control register write lost");

  property p_mc_gap;
    @(posedge hclk) disable iff (!hresetn)
      machine_cycle_stb |=> (!machine_cycle_stb)[*5];
  endproperty
  a_mc_gap: assert property (p_mc_gap)
    else $error("machine cycle shorter than 6 periods");

  property p_half_toggle;
    @(posedge hclk) disable iff (!hresetn)
      s_reg.loaded |=> half_clk != $past(half_clk);
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("half rate clock did not toggle");

  property p_pca12;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[5] && !fast_vec[5]) ##1 (!fast_vec[5])[*8]
        ##1 (!fast_vec[5])[*3] |=> stb_vec[5];
  endproperty
  a_pca12: assert property (p_pca12)
    else $error("counter array slow cycle not 12 periods");

  property p_ser12;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[4] && !fast_vec[4]) ##1 (!fast_vec[4])[*8]
        ##1 (!fast_vec[4])[*3] |=> stb_vec[4];
  endproperty
  a_ser12: assert property (p_ser12)
    else $error("serial port slow cycle not 12 periods");

  property p_t2_12;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[3] && !fast_vec[3]) ##1 (!fast_vec[3])[*8]
        ##1 (!fast_vec[3])[*3] |=> stb_vec[3];
  endproperty
  a_t2_12: assert property (p_t2_12)
    else $error("timer 2 slow cycle not 12 periods");

  property p_t1_12;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[2] && !fast_vec[2]) ##1 (!fast_vec[2])[*8]
        ##1 (!fast_vec[2])[*3] |=> stb_vec[2];
  endproperty
  a_t1_12: assert property (p_t1_12)
    else $error("timer 1 slow cycle not 12 periods");

  property p_t0_6;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[1] && fast_vec[1]) ##1 fast_vec[1][*5] |=> stb_vec[1];
  endproperty
  a_t0_6: assert property (p_t0_6)
    else $error("timer 0 cycle not 6 periods");

  property p_wd12;
    @(posedge hclk) disable iff (!hresetn)
      (stb_vec[6] && !fast_vec[6]) ##1 (!fast_vec[6])[*8]
        ##1 (!fast_vec[6])[*3] |=> stb_vec[6];
  endproperty
  a_wd12: assert property (p_wd12)
    else $error("watchdog slow cycle not 12 periods");

  property p_rd_ctl;
    @(posedge hclk) disable iff (!hresetn)
      (aphase && !hwrite && sel_ctl && !s_reg.wr_pend)
        |=> hrdata == {25'h0, $past(s_reg.ctl)};
  endproperty
  a_rd_ctl: assert property (p_rd_ctl)
    else $error("control register read data wrong");

  property p_rd_stat;
    @(posedge hclk) disable iff (!hresetn)
      (aphase && !hwrite && sel_stat)
        |=> hrdata == {30'h0, $past(s_reg.half), $past(s_reg.mode)};
  endproperty
  a_rd_stat: assert property (p_rd_stat)
    else $error("status register read data wrong");

  property p_rd_other;
    @(posedge hclk) disable iff (!hresetn)
      (aphase && !hwrite && !sel_ctl && !sel_stat) |=> hrdata == 32'h0;
  endproperty
  a_rd_other: assert property (p_rd_other)
    else $error("unmapped read not zero");

  c_enter_dbl: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(s_reg.mode));
  c_leave_dbl: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(s_reg.mode));
  c_ctl_write: cover property (@(posedge hclk) disable iff (!hresetn)
    aphase && hwrite && sel_ctl);
  c_wd_slow: cover property (@(posedge hclk) disable iff (!hresetn)
    stb_vec[6] && s_reg.mode && s_reg.ctl[6]);
  c_read_stat: cover property (@(posedge hclk) disable iff (!hresetn)
    aphase && !hwrite && sel_stat);
endmodule : dsc_clock_gen

// file: test/tb_top.sv
// Purpose: self-checking bench for the double speed clock generator
// Assumes: one AHB-Lite master, zero wait slave, hclk at 100 MHz
// Notes: strobe periods are counted in hclk cycles
`define CHK(nm, g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, half_clk, core_clk_en;
  logic double_speed_active, machine_cycle_stb;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] hardware_config_byte;
  logic [5:0] periph_cycle_stb;
  logic [6:0] stbs;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  assign stbs = {machine_cycle_stb, periph_cycle_stb};
  dsc_clock_gen i_dsc_clock_gen (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .hardware_config_byte(hardware_config_byte), .half_clk(half_clk),
    .core_clk_en(core_clk_en), .double_speed_active(double_speed_active),
    .machine_cycle_stb(machine_cycle_stb), .periph_cycle_stb(periph_cycle_stb));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // one single word transfer, read data kept in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("resp", hresp, 1'b0)
  endtask : bus
  // skip two strobes so a mode change settles, then count one period
  task automatic period(input int i, output int p);
    p = 0;
    repeat (2) begin
      do @(negedge hclk); while (stbs[i] !== 1'b1);
    end
    do begin
      @(negedge hclk);
      p++;
    end while (stbs[i] !== 1'b1);
  endtask : period
  task automatic en_count(output int c);
    c = 0;
    repeat (12) begin
      @(negedge hclk);
      if (core_clk_en === 1'b1) c++;
      if (core_clk_en === 1'b1 && double_speed_active !== 1'b1)
        `CHK("en_phase", half_clk, 1'b1)
    end
  endtask : en_count
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    hardware_config_byte = 8'h00;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h23c, 32'h0);
    `CHK("ctl_reset", rd, 32'h0)
    bus(1'b0, 32'h240, 32'h0);
    `CHK("stat_mode", rd[0], 1'b0)
    period(6, n);
    `CHK("norm_machine", n, 12)
    en_count(n);
    `CHK("norm_core_en", n, 6)
    bus(1'b1, 32'h23c, 32'h7e);
    for (int i = 0; i < 6; i++) begin
      period(i, n);
      `CHK("norm_periph", n, 12)
    end
    $display("test standard done");
    bus(1'b1, 32'h23c, 32'h01);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (double_speed_active !== 1'b1 && n < 5);
    `CHK("mode_delay", (n >= 2 && n <= 3), 1'b1)
    `CHK("mode_on_half_rise", half_clk, 1'b1)
    period(6, n);
    `CHK("dbl_machine", n, 6)
    en_count(n);
    `CHK("dbl_core_en", n, 12)
    bus(1'b0, 32'h240, 32'h0);
    `CHK("stat_dbl", rd[0], 1'b1)
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 32'h23c, 32'h01 | (32'h1 << (i + 1)));
      for (int j = 0; j < 6; j++) begin
        period(j, n);
        `CHK("dbl_periph", n, (i == j) ? 12 : 6)
      end
    end
    $display("test double speed done");
    bus(1'b1, 32'h23c, 32'hffffffff);
    bus(1'b0, 32'h23c, 32'h0);
    `CHK("ctl_mask", rd, 32'h7f)
    bus(1'b0, 32'h100, 32'h0);
    `CHK("unmapped", rd, 32'h0)
    bus(1'b1, 32'h23c, 32'h00);
    period(6, n);
    `CHK("back_norm", n, 12)
    $display("test registers done");
    @(posedge hclk);
    hresetn <= 1'b0;
    hardware_config_byte <= 8'h01;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h23c, 32'h0);
    `CHK("ctl_cfg", rd, 32'h01)
    period(6, n);
    `CHK("cfg_machine", n, 6)
    $display("test config reset done");
    stop_test();
  end
endmodule : tb_top
